// file: rtl/can_event_consts.svh
`ifndef CAN_EVENT_CONSTS_SVH
`define CAN_EVENT_CONSTS_SVH

// Register byte offsets
`define ADDR_W        8
`define OFS_CTRL      8'h00
`define OFS_FLAGS     8'h04
`define OFS_CLEAR     8'h08
`define OFS_ENABLE    8'h0c
`define OFS_TIMER     8'h10

// Control register fields
`define BIT_ON        15
`define REQ_LSB       24
`define CUR_LSB       21
`define MODE_W        3
`define MODE_DISABLE  3'h1
`define MODE_CONFIG   3'h4

// Flag register fields
`define FLAG_W        15
`define BIT_WAKE      14
`define BIT_BUSERR    13
`define BIT_SYSERR    12
`define BIT_RXOVF     11
`define BIT_MODE      3
`define BIT_TMR       2
`define BIT_RXBUF     1
`define BIT_TXBUF     0
`define FLAG_IMPL     15'h780f
`define FLAG_CLEARABLE 15'h680c
`define FLAG_RESTRICT 15'h1000

// Timestamp timer and bus answers
`define TMR_W         16
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

// file: rtl/can_event_pkg.sv
package can_event_pkg;

`include "can_event_consts.svh"

    typedef struct packed {
        logic s1_q;
        logic s2_q;
    } sync_state_t;

    typedef struct packed {
        logic                 awready;
        logic                 aw_ok;
        logic [`ADDR_W-1:0]   aw_addr;
        logic                 wready;
        logic                 w_ok;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [31:0]          rdata;
        logic                 on;
        logic [`MODE_W-1:0]   req_mode;
        logic [`MODE_W-1:0]   cur_mode;
        logic [`FLAG_W-1:0]   flags;
        logic [`FLAG_W-1:0]   en;
        logic [`TMR_W-1:0]    tmr;
        logic                 rx_prev;
        logic                 irq;
    } evt_state_t;

endpackage

// file: rtl/can_sync2.sv
`timescale 1ns/1ps

// Two-flop level synchroniser
module can_sync2
    import can_event_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    input  wire logic d_i,
    output logic      q_o
);

    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d      = q;
        d.s1_q = d_i;
        d.s2_q = q.s1_q;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '{s1_q: 1'b1, s2_q: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign q_o = q.s2_q;

endmodule

// file: rtl/can_event_flag_logic.sv
`timescale 1ns/1ps
`include "can_event_consts.svh"


module can_event_flag_logic
    import can_event_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               awvalid_i,
    output logic                    awready_o,
    input  wire logic [`ADDR_W-1:0] awaddr_i,
    input  wire logic               wvalid_i,
    output logic                    wready_o,
    input  wire logic [31:0]        wdata_i,
    input  wire logic [3:0]         wstrb_i,
    output logic                    bvalid_o,
    input  wire logic               bready_i,
    output logic [1:0]              bresp_o,
    input  wire logic               arvalid_i,
    output logic                    arready_o,
    input  wire logic [`ADDR_W-1:0] araddr_i,
    output logic                    rvalid_o,
    input  wire logic               rready_i,
    output logic [31:0]             rdata_o,
    output logic [1:0]              rresp_o,
    input  wire logic               can_rx_i,
    input  wire logic               bus_err_evt_i,
    input  wire logic               sys_err_evt_i,
    input  wire logic               rx_drop_evt_i,
    input  wire logic               rx_pend_i,
    input  wire logic               tx_pend_i,
    output logic                    irq_o,
    output logic                    module_on_o,
    output logic [`MODE_W-1:0]      current_op_mode_o
);

    ////////////////////////////////////////////////////////////////////////

    localparam evt_state_t ST_RST = '{
        awready:  1'b1,
        wready:   1'b1,
        arready:  1'b1,
        req_mode: `MODE_CONFIG,
        cur_mode: `MODE_DISABLE,
        rx_prev:  1'b1,
        default:  '0
    };

    evt_state_t             q;
    evt_state_t             d;
    logic                   rx_sync;
    logic                   rx_fall;
    logic                   aw_hs;
    logic                   w_hs;
    logic                   ar_hs;
    logic                   wr_go;
    logic                   on_rise;
    logic [31:0]            bm;
    logic [31:0]            ctrl_rd;
    logic [31:0]            nctrl;
    logic [`FLAG_W-1:0]     set;
    logic [`FLAG_W-1:0]     clr;

    ////////////////////////////////////////////////////////////////////////

    // Bus line synchroniser
    can_sync2 u_rx_sync (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .d_i       (can_rx_i),
        .q_o       (rx_sync)
    );

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        d       = q;
        set     = '0;
        clr     = '0;
        nctrl   = '0;
        aw_hs   = awvalid_i && q.awready;
        w_hs    = wvalid_i && q.wready;
        ar_hs   = arvalid_i && q.arready;
        wr_go   = q.aw_ok && q.w_ok && !q.bvalid;
        rx_fall = q.rx_prev && !rx_sync;
        d.rx_prev = rx_sync;
        bm = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}},
              {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
        ctrl_rd = '0;
        ctrl_rd[`BIT_ON] = q.on;
        ctrl_rd[`REQ_LSB +: `MODE_W] = q.req_mode;
        ctrl_rd[`CUR_LSB +: `MODE_W] = q.cur_mode;

        // Write address and data capture
        if (aw_hs) begin
            d.awready = 1'b0;
            d.aw_ok   = 1'b1;
            d.aw_addr = awaddr_i;
        end
        if (w_hs) begin
            d.wready = 1'b0;
            d.w_ok   = 1'b1;
            d.w_data = wdata_i;
            d.w_strb = wstrb_i;
        end

        // Register write
        if (wr_go) begin
            d.aw_ok  = 1'b0;
            d.w_ok   = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `RESP_OKAY;
            case (q.aw_addr)
                `OFS_CTRL: begin
                    nctrl = (ctrl_rd & ~bm) | (q.w_data & bm);
                    d.on = nctrl[`BIT_ON];
                    d.req_mode = nctrl[`REQ_LSB +: `MODE_W];
                end
                `OFS_CLEAR: begin
                    clr = q.w_data[`FLAG_W-1:0] & bm[`FLAG_W-1:0]
                        & `FLAG_CLEARABLE;
                end
                `OFS_ENABLE: begin
                    d.en = ((q.en & ~bm[`FLAG_W-1:0])
                         | (q.w_data[`FLAG_W-1:0] & bm[`FLAG_W-1:0]))
                         & `FLAG_IMPL;
                end
                `OFS_FLAGS, `OFS_TIMER: begin
                    d.bresp = `RESP_OKAY;
                end
                default: begin
                    d.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && bready_i) begin
            d.bvalid  = 1'b0;
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end

        // Register read
        if (ar_hs) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = `RESP_OKAY;
            case (araddr_i)
                `OFS_CTRL: begin
                    d.rdata = ctrl_rd;
                end
                `OFS_FLAGS: begin
                    d.rdata = {17'h0, q.flags & `FLAG_IMPL};
                end
                `OFS_ENABLE: begin
                    d.rdata = {17'h0, q.en};
                end
                `OFS_TIMER: begin
                    d.rdata = {16'h0, q.tmr};
                end
                `OFS_CLEAR: begin
                    d.rdata = '0;
                end
                default: begin
                    d.rdata = '0;
                    d.rresp = `RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && rready_i) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end

        on_rise = d.on && !q.on;
        if (on_rise) begin
            clr = clr | `FLAG_RESTRICT;
        end

        if (!q.on) begin
            d.cur_mode = `MODE_DISABLE;
        end else if (q.req_mode != q.cur_mode) begin
            d.cur_mode = q.req_mode;
            set[`BIT_MODE] = 1'b1;
        end

        if (q.on) begin
            d.tmr = q.tmr + 1'b1;
            set[`BIT_TMR] = &q.tmr;
        end

        set[`BIT_WAKE] = rx_fall && (q.cur_mode == `MODE_DISABLE);
        set[`BIT_BUSERR] = bus_err_evt_i;
        set[`BIT_SYSERR] = sys_err_evt_i;
        set[`BIT_RXOVF] = rx_drop_evt_i;

        d.flags = ((q.flags & ~clr) | set) & `FLAG_IMPL;
        d.flags[`BIT_RXBUF] = rx_pend_i;
        d.flags[`BIT_TXBUF] = tx_pend_i;

        d.irq = |(d.flags & d.en);
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign awready_o         = q.awready;
    assign wready_o          = q.wready;
    assign bvalid_o          = q.bvalid;
    assign bresp_o           = q.bresp;
    assign arready_o         = q.arready;
    assign rvalid_o          = q.rvalid;
    assign rdata_o           = q.rdata;
    assign rresp_o           = q.rresp;
    assign irq_o             = q.irq;
    assign module_on_o       = q.on;
    assign current_op_mode_o = q.cur_mode;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_wake;
        rx_fall && (q.cur_mode == `MODE_DISABLE) |=> q.flags[`BIT_WAKE];
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake flag not set");

    property p_bus_err;
        bus_err_evt_i |=>
            q.flags[`BIT_BUSERR] && (q.irq || !q.en[`BIT_BUSERR]);
    endproperty
    a_bus_err: assert property (p_bus_err)
        else $error("bus error flag not set");

    property p_sys_err;
        sys_err_evt_i |=> q.flags[`BIT_SYSERR];
    endproperty
    a_sys_err: assert property (p_sys_err)
        else $error("system error flag not set");

    property p_rx_ovf;
        rx_drop_evt_i |=> q.flags[`BIT_RXOVF];
    endproperty
    a_rx_ovf: assert property (p_rx_ovf)
        else $error("overflow flag not set");

    property p_unimpl;
        ar_hs && araddr_i == `OFS_FLAGS |=>
            q.rdata[10:4] == 7'h0 && q.flags[10:4] == 7'h0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bits nonzero");

    property p_mode;
        q.on && d.on && q.req_mode != q.cur_mode |=>
            q.cur_mode == $past(q.req_mode) && q.flags[`BIT_MODE];
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode change not flagged");

    property p_tmr;
        q.on && q.tmr == 16'hffff |=> q.tmr == 16'h0 && q.flags[`BIT_TMR];
    endproperty
    a_tmr: assert property (p_tmr)
        else $error("timer wrap not flagged");

    property p_rx_pend;
        q.flags[`BIT_RXBUF] == $past(rx_pend_i);
    endproperty
    a_rx_pend: assert property (p_rx_pend)
        else $error("receive pending mismatch");

    property p_tx_pend;
        q.flags[`BIT_TXBUF] == $past(tx_pend_i);
    endproperty
    a_tx_pend: assert property (p_tx_pend)
        else $error("transmit pending mismatch");

    property p_restrict;
        q.flags[`BIT_SYSERR] && !on_rise |=> q.flags[`BIT_SYSERR];
    endproperty
    a_restrict: assert property (p_restrict)
        else $error("restricted flag cleared by write");

    property p_sticky;
        q.flags[`BIT_BUSERR] && !clr[`BIT_BUSERR] |=> q.flags[`BIT_BUSERR];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sticky flag lost");

    property p_off_mode;
        !q.on |=> q.cur_mode == `MODE_DISABLE;
    endproperty
    a_off_mode: assert property (p_off_mode)
        else $error("mode not disabled while off");

    property p_clear;
        wr_go && q.aw_addr == `OFS_CLEAR && q.w_strb[1] &&
            q.w_data[`BIT_BUSERR] && !bus_err_evt_i |=> !q.flags[`BIT_BUSERR];
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear write ignored");

    c_write: cover property (wr_go ##[1:20] (q.bvalid && bready_i));
    c_read: cover property (ar_hs ##1 q.rvalid);
    c_mode: cover property ($rose(q.flags[`BIT_MODE]));
    c_irq: cover property ($rose(q.irq));
    c_wake: cover property ($rose(q.flags[`BIT_WAKE]));

endmodule

// file: tb/can_node_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Far-side bus node: recessive (high) idle, dominant while waking
module can_node_model (
    input  wire logic ref_clk_i,
    input  wire logic wake_req_i,
    output logic      can_rx_o
);
    logic line_q = 1'b1;
    // Released line returns to its recessive pull-up level
    always @(posedge ref_clk_i) begin
        line_q <= ~wake_req_i;
    end
    assign can_rx_o = line_q;
endmodule

// file: tb/can_event_flag_logic_bench.sv
`timescale 1ns/1ps
`include "can_event_consts.svh"

module can_event_flag_logic_bench;
    import can_event_pkg::*;
    logic               ref_clk = 1'b0;
    logic               rst_b   = 1'b0;
    logic               awvalid = 1'b0;
    logic               wvalid  = 1'b0;
    logic               bready  = 1'b0;
    logic               arvalid = 1'b0;
    logic               rready  = 1'b0;
    logic               wake    = 1'b0;
    logic               rx_pend = 1'b0;
    logic               tx_pend = 1'b0;
    logic [2:0]         evt     = 3'h0;
    logic [`ADDR_W-1:0] awaddr  = 8'h00;
    logic [`ADDR_W-1:0] araddr  = 8'h00;
    logic [31:0]        wdata   = 32'h0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic               irq, mod_on, can_rx;
    logic [1:0]         bresp, rresp;
    logic [31:0]        rdata;
    logic [2:0]         cur_mode;
    int                 n_errors   = 0;
    int                 n_compared = 0;

    ////////////////////////////////////////////////////////////////////
    // Clock, far side and design
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    can_node_model can_node_model_inst (
        .ref_clk_i (ref_clk),
        .wake_req_i(wake),
        .can_rx_o  (can_rx)
    );

    can_event_flag_logic can_event_flag_logic_inst (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
        .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata),
        .wstrb_i(4'hf), .bvalid_o(bvalid), .bready_i(bready),
        .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready),
        .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready),
        .rdata_o(rdata), .rresp_o(rresp), .can_rx_i(can_rx),
        .bus_err_evt_i(evt[2]), .sys_err_evt_i(evt[1]),
        .rx_drop_evt_i(evt[0]), .rx_pend_i(rx_pend),
        .tx_pend_i(tx_pend), .irq_o(irq), .module_on_o(mod_on),
        .current_op_mode_o(cur_mode)
    );

    ////////////////////////////////////////////////////////////////////
    // Checking and bus tasks
    task automatic end_sim;
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int         n;
        logic [1:0] r;
        n = 0;
        r = 2'h3;
        @(posedge ref_clk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        bready  <= 1'b1;
        while (n < 40 && r === 2'h3) begin
            @(posedge ref_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) begin
                bready <= 1'b0;
                r = bresp;
            end
        end
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
        int          n;
        logic [1:0]  r;
        logic [31:0] d;
        n = 0;
        r = 2'h3;
        d = 32'h0;
        @(posedge ref_clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        while (n < 40 && r === 2'h3) begin
            @(posedge ref_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) begin
                rready <= 1'b0;
                r = rresp;
                d = rdata;
            end
        end
        chk({30'h0, r}, {30'h0, er});
        chk(d, exp);
    endtask

    task automatic pulse(input logic [2:0] v);
        @(posedge ref_clk);
        evt <= v;
        @(posedge ref_clk);
        evt <= 3'h0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        #400us;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
        rd(`OFS_CTRL, 32'h0420_0000, `RESP_OKAY);
        rd(8'h40, 32'h0, `RESP_SLVERR);
        wr(8'h40, 32'hffff_ffff, `RESP_SLVERR);
        // Wake activity while the module is off
        @(posedge ref_clk);
        wake <= 1'b1;
        repeat (2) @(posedge ref_clk);
        wake <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(`OFS_FLAGS, 32'h0000_4000, `RESP_OKAY);
        wr(`OFS_CLEAR, 32'h0000_4000, `RESP_OKAY);
        rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
        // Three bus-side events, masked first
        for (int i = 0; i < 3; i++) begin
            pulse(3'h1 << i);
        end
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        rd(`OFS_FLAGS, 32'h0000_3800, `RESP_OKAY);
        wr(`OFS_ENABLE, 32'h0000_780f, `RESP_OKAY);
        rd(`OFS_ENABLE, 32'h0000_780f, `RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_CLEAR, 32'hffff_ffff, `RESP_OKAY);
        wr(`OFS_FLAGS, 32'h0, `RESP_OKAY);
        rd(`OFS_FLAGS, 32'h0000_1000, `RESP_OKAY);
        // Pending levels follow the buffers
        @(posedge ref_clk);
        rx_pend <= 1'b1;
        tx_pend <= 1'b1;
        rd(`OFS_FLAGS, 32'h0000_1003, `RESP_OKAY);
        @(posedge ref_clk);
        rx_pend <= 1'b0;
        tx_pend <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(`OFS_FLAGS, 32'h0000_1000, `RESP_OKAY);
        // Turning on clears restricted flag and changes mode
        wr(`OFS_CTRL, 32'h0400_8000, `RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        chk({28'h0, mod_on, cur_mode}, 32'h0000_000c);
        rd(`OFS_CTRL, 32'h0480_8000, `RESP_OKAY);
        rd(`OFS_FLAGS, 32'h0000_0008, `RESP_OKAY);
        // Timestamp timer wraps after 2^16 cycles
        repeat (65600) @(posedge ref_clk);
        rd(`OFS_FLAGS, 32'h0000_000c, `RESP_OKAY);
        wr(`OFS_CLEAR, 32'h0000_000c, `RESP_OKAY);
        rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        // Reset in mid-run returns set flags to zero
        pulse(3'h4);
        rd(`OFS_FLAGS, 32'h0000_2000, `RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(`OFS_FLAGS, 32'h0, `RESP_OKAY);
        rd(`OFS_CTRL, 32'h0420_0000, `RESP_OKAY);
        rd(`OFS_ENABLE, 32'h0, `RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule
